//--- common/fault_pkg.sv
// Purpose: Shared constants for the fault supervisor.
// Assumes: 100 MHz ref_clk, classic Wishbone with 32-bit data.
// Notes: Fault input positions double as history identifiers.
`default_nettype none
package fault_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int SCAN_MS = 500;
  localparam int SCAN_CYCLES = CLK_HZ / 1000 * SCAN_MS;
  localparam int ROT_S = 1;
  localparam int ROT_CYCLES = CLK_HZ * ROT_S;
  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int LOG_DEPTH = 1024;
  localparam int NUM_FAULTS = 10;
  localparam int NUM_WARNS = 6;
  localparam int NUM_ITEMS = NUM_FAULTS + NUM_WARNS;
  localparam int ID_W = $clog2(NUM_ITEMS);
  localparam int STAMP_W = 32;
  // ------------------------------------------------------------
  // Fault input positions
  // ------------------------------------------------------------
  localparam int FLT_BRIDGE_OC = 0;
  localparam int FLT_BUS_OV = 1;
  localparam int FLT_REGEN_FUSE = 2;
  localparam int FLT_PSU_TEMP = 3;
  localparam int FLT_BRIDGE_TEMP = 4;
  localparam int FLT_MOTOR_TEMP = 5;
  localparam int FLT_PROG_ERR = 6;
  localparam int FLT_RESOLVER = 7;
  localparam int FLT_ANALOG_SUPPLY = 8;
  localparam int FLT_ENC_MISSING = 9;
  localparam logic [NUM_FAULTS-1:0] AMP_MASK = NUM_FAULTS'((1 << FLT_BRIDGE_OC)
    | (1 << FLT_BUS_OV) | (1 << FLT_REGEN_FUSE) | (1 << FLT_PSU_TEMP)
    | (1 << FLT_BRIDGE_TEMP) | (1 << FLT_ANALOG_SUPPLY) | (1 << FLT_ENC_MISSING));
  localparam logic [NUM_FAULTS-1:0] MOT_MASK = NUM_FAULTS'((1 << FLT_MOTOR_TEMP)
    | (1 << FLT_RESOLVER));
  // ------------------------------------------------------------
  // Status codes, modes, registers
  // ------------------------------------------------------------
  localparam logic [1:0] CODE_OK = 2'h0;
  localparam logic [1:0] CODE_MOTOR = 2'h1;
  localparam logic [1:0] CODE_AMP = 2'h2;
  localparam logic [1:0] CODE_LIMIT = 2'h3;
  typedef enum logic [2:0] {
    MODE_VEL_ANALOG = 3'h0,
    MODE_TRQ_ANALOG = 3'h1,
    MODE_DIG_SPEED = 3'h2,
    MODE_STEPPER = 3'h3,
    MODE_POS_POINT = 3'h4,
    MODE_CAN_PROFILE = 3'h5,
    MODE_CAN_INTERP = 3'h6
  } mode_t;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h00;
  localparam logic [7:0] REG_IRQ_MASK = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_LOG_COUNT = 8'h0C;
  localparam logic [7:0] REG_LOG_INDEX = 8'h10;
  localparam logic [7:0] REG_LOG_ID = 8'h14;
  localparam logic [7:0] REG_LOG_STAMP = 8'h18;
  localparam logic [7:0] REG_FAULT_LATCH = 8'h1C;
  localparam logic [7:0] REG_UPTIME = 8'h20;
  localparam int IRQ_W = 3;
  localparam int IRQ_LOGGED = 0;
  localparam int IRQ_FULL = 1;
  localparam int IRQ_LATCHED = 2;
  localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;
  localparam mode_t MODE_RST = MODE_VEL_ANALOG;
endpackage : fault_pkg
`default_nettype wire

//--- hdl/fault_supervisor.sv
// Purpose: Fault history log and two-output status indication.
// Assumes: All inputs synchronous to ref_clk; Wishbone classic slave.
// Notes: History entries are flip-flops and can never be erased.
//
// Summary of operation
// R1 - Scan new faults/warnings every half second
// R2 - Time stamps count from power-up
// R3 - History holds 1024 entries
// R4 - No way to erase history
// R5 - Faults latched until enable rising edge
// R6 - Fault logged once per clear
// R7 - Faults logged enabled or disabled
// R8 - Warnings logged once, only while enabled
// R9 - Code shown only in four control modes
// R10 - Velocity modes: limit, enabled, reached, code
// R11 - Outputs one, two, relay fixed in all modes
// R12 - Two-bit code: ok, motor, amp, limit
// R13 - Logical one means output current flows
// R14 - Drive ok independent of mains
// R15 - Amplifier and motor fault groups
// R16 - Either limit switch gives limit code
// R17 - Priority amplifier, motor, then limit
// R18 - Entry holds identifier and stamp; stop when full
// R19 - Several active items rotate each second
`default_nettype none
module fault_supervisor
  import fault_pkg::*;
#(
  parameter int DEPTH = LOG_DEPTH,
  parameter int SCAN_CYC = SCAN_CYCLES,
  parameter int ROT_CYC = ROT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic irq,
  input wire logic [NUM_FAULTS-1:0] fault_in,
  input wire logic [NUM_WARNS-1:0] warn_in,
  input wire logic enable_in,
  input wire logic limit_cw,
  input wire logic limit_ccw,
  input wire logic limit_active,
  input wire logic speed_reached,
  input wire logic following_error,
  input wire logic system_ready,
  input wire logic [2:0] user_out,
  output logic discrete_out_one,
  output logic discrete_out_two,
  output logic discrete_out_three,
  output logic discrete_out_four,
  output logic discrete_out_five,
  output logic relay_ready
);
  localparam int IDX_W = $clog2(DEPTH);

  // ------------------------------------------------------------
  // Timebase
  // ------------------------------------------------------------
  logic [31:0] scan_cnt_q;
  logic [31:0] rot_cnt_q;
  logic [STAMP_W-1:0] uptime_q;
  logic scan_tick;
  logic rot_tick;
  logic en_q;
  logic en_rise;

  assign scan_tick = (scan_cnt_q == 32'(SCAN_CYC - 1));
  assign rot_tick = (rot_cnt_q == 32'(ROT_CYC - 1));
  assign en_rise = enable_in & ~en_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scan_cnt_q <= 32'h0;
    end else begin
      scan_cnt_q <= scan_tick ? 32'h0 : scan_cnt_q + 32'h1; // R1
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rot_cnt_q <= 32'h0;
    end else begin
      rot_cnt_q <= rot_tick ? 32'h0 : rot_cnt_q + 32'h1; // R19
    end
  end

  // Half-second units; restarts with every power-up reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      uptime_q <= '0;
    end else if (scan_tick) begin
      uptime_q <= uptime_q + STAMP_W'(1); // R2
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      en_q <= 1'b0;
    end else begin
      en_q <= enable_in;
    end
  end

  // ------------------------------------------------------------
  // Latching and first-occurrence tracking
  // ------------------------------------------------------------
  logic [NUM_FAULTS-1:0] latch_q;
  logic [NUM_FAULTS-1:0] flt_done_q;
  logic [NUM_WARNS-1:0] warn_done_q;
  logic [NUM_ITEMS-1:0] pend_q;
  logic [NUM_ITEMS-1:0] cand;
  logic [ID_W-1:0] wr_id;
  logic wr_en;
  logic full;

  // A fault present in the clearing cycle survives the clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      latch_q <= '0;
    end else begin
      latch_q <= (en_rise ? '0 : latch_q) | fault_in; // R5
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flt_done_q <= '0;
    end else begin
      // A clear that meets a scan keeps only faults still present, so a
      // cleared fault is not marked as logged and its next occurrence logs
      if (en_rise) begin
        flt_done_q <= scan_tick ? (latch_q & fault_in) : '0; // R6
      end else begin
        flt_done_q <= flt_done_q | (scan_tick ? latch_q : '0); // R6 R7
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      warn_done_q <= '0;
    end else begin
      warn_done_q <= (en_rise ? '0 : warn_done_q)
        | ((scan_tick && enable_in) ? warn_in : '0); // R8
    end
  end

  assign cand = {warn_in & ~warn_done_q & {NUM_WARNS{enable_in}}, // R8
                 latch_q & ~flt_done_q}; // R6

  function automatic logic [ID_W-1:0] lowest(input logic [NUM_ITEMS-1:0] v);
    logic [ID_W-1:0] r;
    r = '0;
    for (int i = NUM_ITEMS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = ID_W'(i);
      end
    end
    return r;
  endfunction : lowest

  assign wr_id = lowest(pend_q);
  assign wr_en = (pend_q != '0) && !full;

  // One entry is written per cycle after each scan
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q & ~(wr_en ? NUM_ITEMS'(1) << wr_id : '0))
        | (scan_tick ? cand : '0); // R1
    end
  end

  // ------------------------------------------------------------
  // History store
  // ------------------------------------------------------------
  logic [ID_W-1:0] id_mem_q [DEPTH];
  logic [STAMP_W-1:0] stamp_mem_q [DEPTH];
  logic [IDX_W:0] count_q;

  assign full = (count_q == (IDX_W+1)'(DEPTH)); // R3

  // Write-once storage; nothing else ever addresses it for writing
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      id_mem_q[count_q[IDX_W-1:0]] <= wr_id; // R18
      stamp_mem_q[count_q[IDX_W-1:0]] <= uptime_q; // R2
    end
  end

  // Counts only upward; when full, later items are dropped
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_q <= '0;
    end else if (wr_en) begin
      count_q <= count_q + (IDX_W+1)'(1); // R4 R18
    end
  end

  // ------------------------------------------------------------
  // Status code and rotation
  // ------------------------------------------------------------
  logic amp_act;
  logic mot_act;
  logic lim_act;
  logic [2:0] grp_act;
  logic [1:0] sel_q;
  logic [1:0] show;
  logic [1:0] code;
  logic ind_mode;
  mode_t mode_q;

  // Drive ok ignores mains; supply faults arrive only when detected
  assign amp_act = |(latch_q & AMP_MASK); // R14 R15
  assign mot_act = |(latch_q & MOT_MASK); // R15
  assign lim_act = limit_cw | limit_ccw; // R16
  assign grp_act = {lim_act, mot_act, amp_act};

  function automatic logic [1:0] next_grp(input logic [1:0] cur, input logic [2:0] act);
    logic [1:0] n;
    logic [1:0] c;
    n = cur;
    c = cur;
    for (int k = 0; k < 3; k++) begin
      c = (c == 2'h2) ? 2'h0 : c + 2'h1;
      if (act[c] && n == cur) begin
        n = c;
      end
    end
    return n;
  endfunction : next_grp

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sel_q <= 2'h0;
    end else if (rot_tick) begin
      sel_q <= next_grp(sel_q, grp_act); // R19
    end
  end

  always_comb begin
    if (grp_act[sel_q]) begin
      show = sel_q;
    end else begin
      show = amp_act ? 2'h0 : (mot_act ? 2'h1 : 2'h2); // R17
    end
    case (show)
      2'h0: code = amp_act ? CODE_AMP : CODE_OK; // R12
      2'h1: code = CODE_MOTOR;
      2'h2: code = lim_act ? CODE_LIMIT : CODE_OK;
      default: code = CODE_OK;
    endcase
  end

  assign ind_mode = (mode_q == MODE_VEL_ANALOG) || (mode_q == MODE_TRQ_ANALOG)
    || (mode_q == MODE_DIG_SPEED) || (mode_q == MODE_STEPPER); // R9

  // ------------------------------------------------------------
  // Discrete outputs (a one drives current in the output stage)
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      discrete_out_one <= 1'b0;
      discrete_out_two <= 1'b0;
      discrete_out_three <= 1'b0;
      discrete_out_four <= 1'b0;
      discrete_out_five <= 1'b0;
      relay_ready <= 1'b0;
    end else begin
      discrete_out_one <= limit_active; // R11 R13
      discrete_out_two <= enable_in; // R11
      relay_ready <= system_ready; // R11
      case (mode_q)
        MODE_VEL_ANALOG, MODE_TRQ_ANALOG, MODE_DIG_SPEED: begin
          discrete_out_three <= speed_reached; // R10
          {discrete_out_five, discrete_out_four} <= code; // R10 R12
        end
        MODE_STEPPER: begin
          discrete_out_three <= following_error;
          {discrete_out_five, discrete_out_four} <= code; // R9
        end
        MODE_POS_POINT, MODE_CAN_INTERP: begin
          {discrete_out_five, discrete_out_four, discrete_out_three} <= user_out; // R11
        end
        default: begin
          {discrete_out_five, discrete_out_four, discrete_out_three} <= 3'h0; // R11
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Wishbone slave and interrupts
  // ------------------------------------------------------------
  logic ack_q;
  logic acc;
  logic wr;
  logic [31:0] be;
  logic [31:0] wd;
  logic [31:0] rd;
  logic [IRQ_W-1:0] status_q;
  logic [IRQ_W-1:0] mask_q;
  logic [IRQ_W-1:0] ev;
  logic [IDX_W-1:0] index_q;
  logic idx_ok;

  assign acc = cyc_i & stb_i & ~ack_q;
  assign wr = acc & we_i;
  assign ack_o = ack_q;
  assign be = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign wd = dat_i & be;
  assign idx_ok = ({1'b0, index_q} < count_q);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc;
    end
  end

  always_comb begin
    case (adr_i)
      REG_IRQ_STATUS: rd = 32'(status_q);
      REG_IRQ_MASK: rd = 32'(mask_q);
      REG_CTRL: rd = 32'(mode_q);
      REG_LOG_COUNT: rd = 32'(count_q);
      REG_LOG_INDEX: rd = 32'(index_q);
      REG_LOG_ID: rd = idx_ok ? 32'(id_mem_q[index_q]) : 32'h0;
      REG_LOG_STAMP: rd = idx_ok ? 32'(stamp_mem_q[index_q]) : 32'h0;
      REG_FAULT_LATCH: rd = 32'(latch_q);
      REG_UPTIME: rd = 32'(uptime_q);
      default: rd = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dat_o <= 32'h0;
    end else if (acc && !we_i) begin
      dat_o <= rd;
    end
  end

  // Count and store are read-only: no write path can remove entries
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_q <= MASK_RST;
      mode_q <= MODE_RST;
      index_q <= '0;
    end else if (wr) begin
      case (adr_i)
        REG_IRQ_MASK: mask_q <= (mask_q & ~be[IRQ_W-1:0]) | wd[IRQ_W-1:0];
        REG_CTRL: mode_q <= mode_t'((mode_q & ~be[2:0]) | wd[2:0]);
        REG_LOG_INDEX: index_q <= (index_q & ~be[IDX_W-1:0]) | wd[IDX_W-1:0];
        default: index_q <= index_q; // R4
      endcase
    end
  end

  assign ev[IRQ_LOGGED] = wr_en;
  assign ev[IRQ_FULL] = wr_en && (count_q == (IDX_W+1)'(DEPTH - 1));
  assign ev[IRQ_LATCHED] = |(fault_in & ~latch_q);

  // Set beats a same-cycle write-one clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~((wr && adr_i == REG_IRQ_STATUS) ? wd[IRQ_W-1:0] : '0)) | ev;
    end
  end

  assign irq = |(status_q & mask_q);

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_latch_hold;
    !en_rise |=> (latch_q & $past(latch_q)) == $past(latch_q);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("fault latch lost"); // R5

  property p_clear;
    (en_rise && fault_in == '0) |=> latch_q == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("enable edge did not clear"); // R5

  property p_once;
    wr_en |=> !pend_q[$past(wr_id)];
  endproperty
  a_once: assert property (p_once) else $error("entry left pending"); // R6

  property p_warn_en;
    (scan_tick && !enable_in) |=> warn_done_q == $past(warn_done_q);
  endproperty
  a_warn_en: assert property (p_warn_en) else $error("warning taken while disabled"); // R8

  property p_grow;
    1'b1 |=> count_q >= $past(count_q);
  endproperty
  a_grow: assert property (p_grow) else $error("history shrank"); // R4

  property p_full;
    full |=> !wr_en && count_q == $past(count_q);
  endproperty
  a_full: assert property (p_full) else $error("write past full store"); // R18

  property p_code_amp;
    (amp_act && ind_mode) |=> {discrete_out_five, discrete_out_four} != CODE_OK;
  endproperty
  a_code_amp: assert property (p_code_amp) else $error("active fault shows ok"); // R12

  property p_code_ok;
    (grp_act == 3'h0 && ind_mode) |=> {discrete_out_five, discrete_out_four} == CODE_OK;
  endproperty
  a_code_ok: assert property (p_code_ok) else $error("ok code missing"); // R14

  property p_out12;
    1'b1 |=> discrete_out_one == $past(limit_active) && discrete_out_two == $past(enable_in);
  endproperty
  a_out12: assert property (p_out12) else $error("output one or two wrong"); // R11

  property p_ack;
    (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse");

  c_log: cover property (wr_en);
  c_full: cover property (full);
  c_clear: cover property (en_rise && latch_q != '0);
  c_rot: cover property (rot_tick && $countones(grp_act) > 1);
endmodule : fault_supervisor
`default_nettype wire

//--- test/fault_supervisor_tb.sv
// Purpose: Self-checking bench for the fault supervisor.
// Assumes: Short scan, rotation and depth counts for a fast run.
// Notes: Expected values come from package constants, bench counts and literals.
`default_nettype none
module fault_supervisor_tb;
  import fault_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 20;
  localparam int RC = 40;
  localparam int DP = 8;
  logic ref_clk, rst, cyc_i, stb_i, we_i, ack_o, irq, enable_in;
  logic [7:0] adr_i;
  logic [31:0] dat_i, dat_o, rd, st0;
  logic [3:0] sel_i;
  logic [NUM_FAULTS-1:0] fault_in;
  logic [NUM_WARNS-1:0] warn_in;
  logic limit_cw, limit_ccw, limit_active, speed_reached, following_error, system_ready;
  logic [2:0] user_out;
  logic d_one, d_two, d_three, d_four, d_five, relay_ready;
  logic [1:0] code_seen;
  int n_fail, samples_checked, k, exp_n, seen_amp, seen_mot;
  fault_supervisor #(.DEPTH(DP), .SCAN_CYC(SC), .ROT_CYC(RC)) u_fault_supervisor (
    .ref_clk(ref_clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
    .irq(irq), .fault_in(fault_in), .warn_in(warn_in), .enable_in(enable_in),
    .limit_cw(limit_cw), .limit_ccw(limit_ccw), .limit_active(limit_active),
    .speed_reached(speed_reached), .following_error(following_error),
    .system_ready(system_ready), .user_out(user_out), .discrete_out_one(d_one),
    .discrete_out_two(d_two), .discrete_out_three(d_three),
    .discrete_out_four(d_four), .discrete_out_five(d_five), .relay_ready(relay_ready));
  plc_model u_plc_model (.ref_clk(ref_clk), .rst(rst), .discrete_out_four(d_four),
    .discrete_out_five(d_five), .code_seen(code_seen));
  // ------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'hF;
    for (i = 0; i < 100; i++) begin
      @(posedge ref_clk);
      if (ack_o === 1'b1) break;
    end
    if (i == 100) n_fail++;
    rd = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
  endtask : wb
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t register got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t output got %b expected %b", $time, got, exp);
    end
  endtask : chk_pin
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk_reg(rd, exp);
  endtask : rd_reg
  task automatic pulse(input int b);
    @(posedge ref_clk) fault_in <= NUM_FAULTS'(1) << b;
    @(posedge ref_clk) fault_in <= '0;
  endtask : pulse
  task automatic clear_edge;
    @(posedge ref_clk) enable_in <= 1'b0;
    @(posedge ref_clk) enable_in <= 1'b1;
    tick(3);
  endtask : clear_edge
  task automatic give_verdict;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  // ------------------------------------------------------------
  // Clock, watchdog
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Whole sequence needs about a thousand cycles; far more means a hang
  initial begin
    #200000;
    n_fail++;
    give_verdict();
  end
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    n_fail = 0; samples_checked = 0; rst = 1'b1; cyc_i = 0; stb_i = 0; we_i = 0;
    adr_i = '0; dat_i = '0; sel_i = '0; fault_in = '0; warn_in = '0; enable_in = 0;
    limit_cw = 0; limit_ccw = 0; limit_active = 0; speed_reached = 0;
    following_error = 0; system_ready = 0; user_out = '0;
    tick(12);
    rst <= 1'b0;
    rd_reg(REG_CTRL, 32'h0);
    rd_reg(REG_IRQ_MASK, 32'h0);
    rd_reg(REG_LOG_COUNT, 32'h0);
    rd_reg(8'h40, 32'h0);
    chk_pin({1'b0, irq}, 2'h0);
    wb(1'b1, REG_IRQ_MASK, 32'h7);
    pulse(FLT_BRIDGE_OC);
    tick(3);
    rd_reg(REG_FAULT_LATCH, 32'h1);
    chk_pin(code_seen, CODE_AMP);
    tick(2 * SC + 4);
    rd_reg(REG_LOG_COUNT, 32'h1);
    wb(1'b1, REG_LOG_INDEX, 32'h0);
    rd_reg(REG_LOG_ID, 32'(FLT_BRIDGE_OC));
    wb(1'b0, REG_LOG_STAMP, 32'h0);
    st0 = rd;
    chk_pin({1'b0, irq}, 2'h1);
    wb(1'b1, REG_IRQ_STATUS, 32'h7);
    rd_reg(REG_IRQ_STATUS, 32'h0);
    chk_pin({1'b0, irq}, 2'h0);
    pulse(FLT_BRIDGE_OC);
    tick(2 * SC + 4);
    rd_reg(REG_LOG_COUNT, 32'h1);
    wb(1'b1, REG_LOG_COUNT, 32'h0);
    rd_reg(REG_LOG_COUNT, 32'h1);
    clear_edge();
    rd_reg(REG_FAULT_LATCH, 32'h0);
    chk_pin(code_seen, CODE_OK);
    chk_pin({1'b0, d_two}, 2'h1);
    // Warning held across four scans logs only once
    warn_in <= 6'h1;
    tick(4 * SC + 4);
    rd_reg(REG_LOG_COUNT, 32'h2);
    wb(1'b1, REG_LOG_INDEX, 32'h1);
    rd_reg(REG_LOG_ID, 32'(NUM_FAULTS));
    warn_in <= 6'h0;
    enable_in <= 1'b0;
    tick(2);
    warn_in <= 6'h2;
    tick(2 * SC + 4);
    rd_reg(REG_LOG_COUNT, 32'h2);
    warn_in <= 6'h0;
    pulse(FLT_RESOLVER);
    tick(3);
    chk_pin(code_seen, CODE_MOTOR);
    tick(2 * SC + 4);
    rd_reg(REG_LOG_COUNT, 32'h3);
    wb(1'b1, REG_LOG_INDEX, 32'h2);
    wb(1'b0, REG_LOG_STAMP, 32'h0);
    chk_pin({1'b0, rd > st0}, 2'h1);
    // Amplifier and motor latched together: both codes must be shown
    pulse(FLT_BRIDGE_TEMP);
    seen_amp = 0; seen_mot = 0;
    for (k = 0; k < 3 * RC + 10; k++) begin
      @(posedge ref_clk);
      if (code_seen === CODE_AMP) seen_amp++;
      if (code_seen === CODE_MOTOR) seen_mot++;
    end
    chk_pin({seen_amp > 0, seen_mot > 0}, 2'h3);
    clear_edge();
    limit_ccw <= 1'b1;
    tick(3);
    chk_pin(code_seen, CODE_LIMIT);
    limit_ccw <= 1'b0; limit_cw <= 1'b1;
    tick(3);
    chk_pin(code_seen, CODE_LIMIT);
    limit_cw <= 1'b0;
    // Output routing per control mode
    speed_reached <= 1'b1; user_out <= 3'h5; limit_active <= 1'b1; system_ready <= 1'b1;
    for (k = 0; k < 8; k++) begin
      wb(1'b1, REG_CTRL, 32'(k));
      tick(3);
      chk_pin({d_one, relay_ready}, 2'h3);
      chk_pin({1'b0, d_three}, {1'b0, k <= 2 || k == 4 || k == 6});
      chk_pin({1'b0, d_five}, {1'b0, k == 4 || k == 6});
    end
    wb(1'b1, REG_CTRL, 32'h0);
    // Fill the store, then four more faults must be refused
    exp_n = 4;
    for (k = 0; k < DP; k++) begin
      clear_edge();
      pulse(FLT_BUS_OV);
      tick(2 * SC + 4);
      rd_reg(REG_LOG_COUNT, 32'(exp_n < DP ? exp_n + 1 : DP));
      if (exp_n < DP) exp_n++;
    end
    wb(1'b0, REG_IRQ_STATUS, 32'h0);
    chk_reg(rd & 32'h2, 32'h2);
    give_verdict();
  end
endmodule : fault_supervisor_tb
`default_nettype wire

//--- test/plc_model.sv
// Purpose: Controller-side reader of the two-bit status code.
// Assumes: Outputs are levels synchronous to ref_clk.
// Notes: Samples each cycle; one means current flows in the stage.
`default_nettype none
module plc_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic discrete_out_four,
  input wire logic discrete_out_five,
  output logic [1:0] code_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Code decode
  // ------------------------------------------------------------
  // Output five is the upper bit of the code
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      code_seen <= 2'h0;
    end else begin
      code_seen <= {discrete_out_five, discrete_out_four};
    end
  end
endmodule : plc_model
`default_nettype wire
